// >>> common/spief_pkg.sv
// Package for the second-bank peripheral interrupt enable and flag block.
// Assumes a byte-wide register port with read data one cycle after the read strobe.
package spief_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] ENABLE_OFFSET = 8'h8d;
   localparam logic [7:0] FLAGS_OFFSET = 8'h0d;
   localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h40;
   localparam logic [7:0] IRQ_MASK_OFFSET = 8'h41;
   localparam int unsigned CAPCMP_POS = 0;
   localparam int unsigned BUSCOL_POS = 3;
   localparam int unsigned EEWR_POS = 4;
   localparam int unsigned RSVD_POS = 6;
   localparam logic [7:0] ENABLE_IMPL_MASK = 8'h59;
   localparam logic [7:0] FLAG_EVT_MASK = 8'h19;
   localparam logic [7:0] RESET_VALUE = 8'h00;

   typedef struct packed {
      logic eeprom_write_done;
      logic bus_collision;
      logic capcmp_two;
   } spief_events_s;
endpackage : spief_pkg

// >>> rtl/spief_irq_bank2.sv
// Second-bank peripheral interrupt enable and flag registers with a gated request.
// Assumes event inputs are single-cycle pulses from logic on the same clock.
//
// Chosen here: the strobed register port.
module spief_irq_bank2 (
   input wire logic clk, // System clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic [7:0] reg_addr, // Register address.
   input wire logic [7:0] reg_wdata, // Write data.
   input wire logic reg_wr, // Write strobe.
   input wire logic reg_rd, // Read strobe.
   output logic [7:0] reg_rdata, // Read data, one cycle after the strobe.
   input wire spief_pkg::spief_events_s evt, // Event pulses from the sources.
   output logic periph_irq_req, // Gated peripheral request to the core.
   output logic irq // Level interrupt from the status and mask pair.
);
   logic [7:0] enable_reg;
   logic [7:0] flags_reg;
   logic [7:0] status_reg;
   logic [7:0] mask_reg;
   logic [7:0] evt_vec;
   logic wr_en, wr_fl, wr_st, wr_mk;

   always_comb begin
      evt_vec = 8'h00;
      evt_vec[spief_pkg::EEWR_POS] = evt.eeprom_write_done;
      evt_vec[spief_pkg::BUSCOL_POS] = evt.bus_collision;
      evt_vec[spief_pkg::CAPCMP_POS] = evt.capcmp_two;
   end

   assign wr_en = reg_wr && (reg_addr == spief_pkg::ENABLE_OFFSET);
   assign wr_fl = reg_wr && (reg_addr == spief_pkg::FLAGS_OFFSET);
   assign wr_st = reg_wr && (reg_addr == spief_pkg::IRQ_STATUS_OFFSET);
   assign wr_mk = reg_wr && (reg_addr == spief_pkg::IRQ_MASK_OFFSET);

   // Unimplemented bits are masked out so they never store anything.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         enable_reg <= spief_pkg::RESET_VALUE;
      end else if (wr_en) begin
         enable_reg <= reg_wdata & spief_pkg::ENABLE_IMPL_MASK;
      end
   end

   // Flags are set by events independent of any enable; a set wins over a software write.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_reg <= spief_pkg::RESET_VALUE;
      end else if (wr_fl) begin
         flags_reg <= (reg_wdata & spief_pkg::FLAG_EVT_MASK) | evt_vec;
      end else begin
         flags_reg <= flags_reg | evt_vec;
      end
   end

   // Sticky status mirrors new events, cleared by writing one; the set wins.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_reg <= spief_pkg::RESET_VALUE;
      end else if (wr_st) begin
         status_reg <= (status_reg & ~reg_wdata) | evt_vec;
      end else begin
         status_reg <= status_reg | evt_vec;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_reg <= spief_pkg::RESET_VALUE;
      end else if (wr_mk) begin
         mask_reg <= reg_wdata & spief_pkg::FLAG_EVT_MASK;
      end
   end

   // Request is registered, so it trails the flag or enable by one cycle.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         periph_irq_req <= 1'b0;
      end else begin
         periph_irq_req <= |(flags_reg & enable_reg & spief_pkg::FLAG_EVT_MASK);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_reg & mask_reg);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            spief_pkg::ENABLE_OFFSET: reg_rdata <= enable_reg;
            spief_pkg::FLAGS_OFFSET: reg_rdata <= flags_reg;
            spief_pkg::IRQ_STATUS_OFFSET: reg_rdata <= status_reg;
            spief_pkg::IRQ_MASK_OFFSET: reg_rdata <= mask_reg;
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   property p_unimpl_zero;
      @(posedge clk) disable iff (!rst_n)
         (enable_reg & ~spief_pkg::ENABLE_IMPL_MASK) == 8'h00;
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented enable bit set");

   property p_ee_set;
      @(posedge clk) disable iff (!rst_n)
         evt.eeprom_write_done |=> flags_reg[spief_pkg::EEWR_POS];
   endproperty
   a_ee_set: assert property (p_ee_set) else $error("eeprom flag not set");

   property p_bc_set;
      @(posedge clk) disable iff (!rst_n)
         evt.bus_collision |=> flags_reg[spief_pkg::BUSCOL_POS];
   endproperty
   a_bc_set: assert property (p_bc_set) else $error("collision flag not set");

   property p_cc_set;
      @(posedge clk) disable iff (!rst_n)
         evt.capcmp_two |=> flags_reg[spief_pkg::CAPCMP_POS];
   endproperty
   a_cc_set: assert property (p_cc_set) else $error("capcmp flag not set");

   property p_flag_sticky;
      @(posedge clk) disable iff (!rst_n)
         (flags_reg[spief_pkg::EEWR_POS] && !wr_fl) |=> flags_reg[spief_pkg::EEWR_POS];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without write");

   property p_ee_en;
      @(posedge clk) disable iff (!rst_n)
         (flags_reg[spief_pkg::EEWR_POS] && enable_reg[spief_pkg::EEWR_POS]) |=> periph_irq_req;
   endproperty
   a_ee_en: assert property (p_ee_en) else $error("eeprom request missing");

   property p_bc_en;
      @(posedge clk) disable iff (!rst_n)
         (flags_reg[spief_pkg::BUSCOL_POS] && enable_reg[spief_pkg::BUSCOL_POS])
            |=> periph_irq_req;
   endproperty
   a_bc_en: assert property (p_bc_en) else $error("collision request missing");

   property p_cc_en;
      @(posedge clk) disable iff (!rst_n)
         (flags_reg[spief_pkg::CAPCMP_POS] && enable_reg[spief_pkg::CAPCMP_POS])
            |=> periph_irq_req;
   endproperty
   a_cc_en: assert property (p_cc_en) else $error("capcmp request missing");

   property p_req_exact;
      @(posedge clk) disable iff (!rst_n)
         ##1 periph_irq_req == $past(|(flags_reg & enable_reg & spief_pkg::FLAG_EVT_MASK));
   endproperty
   a_req_exact: assert property (p_req_exact) else $error("request mismatch");

   property p_rd_unimpl;
      @(posedge clk) disable iff (!rst_n)
         (reg_rd && reg_addr == spief_pkg::ENABLE_OFFSET)
            |=> (reg_rdata & ~spief_pkg::ENABLE_IMPL_MASK) == 8'h00;
   endproperty
   a_rd_unimpl: assert property (p_rd_unimpl) else $error("enable read not zero");

   property p_flag_unimpl;
      @(posedge clk) disable iff (!rst_n)
         (flags_reg & ~spief_pkg::FLAG_EVT_MASK) == 8'h00;
   endproperty
   a_flag_unimpl: assert property (p_flag_unimpl) else $error("unused flag bit set");

   // A software clear must stick unless the same source fires in that cycle.
   property p_flag_clear;
      @(posedge clk) disable iff (!rst_n)
         (wr_fl && !reg_wdata[spief_pkg::EEWR_POS] && !evt.eeprom_write_done)
            |=> !flags_reg[spief_pkg::EEWR_POS];
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("eeprom flag not cleared");

   // With every enable clear, no flag may reach the core.
   property p_blocked;
      @(posedge clk) disable iff (!rst_n)
         ((enable_reg & spief_pkg::FLAG_EVT_MASK) == 8'h00) |=> !periph_irq_req;
   endproperty
   a_blocked: assert property (p_blocked) else $error("request while disabled");

   // Event to flag to request takes two edges while the enable holds.
   sequence s_ee_armed;
      evt.eeprom_write_done && enable_reg[spief_pkg::EEWR_POS] && !wr_en;
   endsequence

   sequence s_ee_raised;
      flags_reg[spief_pkg::EEWR_POS] ##1 periph_irq_req;
   endsequence

   property p_ee_chain;
      @(posedge clk) disable iff (!rst_n)
         s_ee_armed |=> s_ee_raised;
   endproperty
   a_ee_chain: assert property (p_ee_chain) else $error("eeprom event gave no request");

   property p_st_clear;
      @(posedge clk) disable iff (!rst_n)
         (wr_st && reg_wdata[spief_pkg::EEWR_POS] && !evt.eeprom_write_done)
            |=> !status_reg[spief_pkg::EEWR_POS];
   endproperty
   a_st_clear: assert property (p_st_clear) else $error("status bit not cleared");

   property p_irq_on;
      @(posedge clk) disable iff (!rst_n)
         ((status_reg & mask_reg) != 8'h00) |=> irq;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("interrupt missing");

   property p_irq_off;
      @(posedge clk) disable iff (!rst_n)
         ((status_reg & mask_reg) == 8'h00) |=> !irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt without cause");

   // Read data stand for one cycle only, so a stale byte cannot be taken twice.
   property p_rdata_idle;
      @(posedge clk) disable iff (!rst_n)
         !reg_rd |=> (reg_rdata == 8'h00);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data without a read");
endmodule // spief_irq_bank2

// >>> testbench/spief_evt_src.sv
// Model of the peripheral event sources.
// Assumes the bench asks for each pulse for one clock only.
module spief_evt_src (
   input wire logic clk, // System clock.
   input wire logic [2:0] fire, // Events asked for by the bench.
   output spief_pkg::spief_events_s evt // Event pulses to the block.
);
   timeunit 1ns;
   timeprecision 1ps;
   // Registered so pulses leave just after an edge, as real sources do.
   always_ff @(posedge clk) begin
      evt <= fire;
   end
endmodule // spief_evt_src

// >>> testbench/spief_irq_bank2_tb.sv
// Self-checking bench for the second-bank interrupt enable and flag block.
// Assumes read data appear in the cycle after the read strobe.
module spief_irq_bank2_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, rd_q = 0, req, irq;
   logic [7:0] addr = 0, wdata = 0, rdata;
   logic [2:0] fire = 0;
   logic [31:0] lf = 32'he58e8d7f;
   logic [7:0] bitv [3] = '{8'h01, 8'h08, 8'h10};
   logic [7:0] exp_q [$];
   spief_pkg::spief_events_s evt;
   int n_mismatch = 0, n_checks = 0, cyc = 0;
   spief_evt_src spief_evt_src_i (.clk(clk), .fire(fire), .evt(evt));
   spief_irq_bank2 spief_irq_bank2_i (.clk(clk), .rst_n(rst_n), .reg_addr(addr),
      .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .evt(evt),
      .periph_irq_req(req), .irq(irq));
   initial forever #2.5 clk = ~clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      n_checks++;
      if (got !== want) begin
         n_mismatch++;
         $display("BAD %0t got %h want %h", $time, got, want);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // For a read, d is the value expected back.
   task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      wr <= w;
      rd <= r;
      addr <= a;
      wdata <= d;
      if (r) exp_q.push_back(d);
      @(posedge clk);
   endtask
   task automatic idle(input int n);
      wr <= 0;
      rd <= 0;
      fire <= 0;
      repeat (n) @(posedge clk);
   endtask
   task automatic pulse(input logic [2:0] e);
      wr <= 0;
      rd <= 0;
      fire <= e;
      @(posedge clk);
      idle(4);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (rd_q) chk(rdata, exp_q.pop_front());
      rd_q <= rd;
      if (cyc == 3000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      bus(0, 1, 8'h8d, 8'h00);
      bus(0, 1, 8'h0d, 8'h00);
      bus(1, 0, 8'h8d, 8'hbf);
      bus(0, 1, 8'h8d, 8'h19);
      for (int i = 0; i < 4; i++) begin
         lf = lfsr(lf);
         bus(1, 0, 8'h8d, lf[7:0] & 8'hbf);
         bus(0, 1, 8'h8d, lf[7:0] & 8'h19);
      end
      bus(1, 0, 8'h8d, 8'h00);
      pulse(3'h7);
      chk({7'h0, req}, 8'h00);
      bus(0, 1, 8'h0d, 8'h19);
      for (int k = 0; k < 3; k++) begin
         bus(1, 0, 8'h0d, 8'h00);
         bus(1, 0, 8'h8d, bitv[k]);
         pulse(~(3'h1 << k));
         chk({7'h0, req}, 8'h00);
         pulse(3'h1 << k);
         chk({7'h0, req}, 8'h01);
      end
      bus(1, 0, 8'h40, 8'hff);
      bus(1, 0, 8'h41, 8'h10);
      pulse(3'h4);
      chk({7'h0, irq}, 8'h01);
      bus(1, 0, 8'h40, 8'h10);
      idle(2);
      chk({7'h0, irq}, 8'h00);
      bus(0, 1, 8'h41, 8'h10);
      bus(0, 1, 8'h40, 8'h00);
      bus(1, 0, 8'h55, 8'hff);
      bus(0, 1, 8'h55, 8'h00);
      bus(0, 1, 8'h8d, 8'h10);
      idle(2);
      chk({7'h0, req}, 8'h01);
      // A reset in mid-run must drop the live request and the enable and flag registers.
      rst_n <= 0;
      idle(2);
      chk({7'h0, req}, 8'h00);
      rst_n <= 1;
      @(posedge clk);
      bus(0, 1, 8'h8d, 8'h00);
      bus(0, 1, 8'h0d, 8'h00);
      idle(3);
      report_and_stop();
   end
endmodule // spief_irq_bank2_tb
